// >>> wwdc_pkg.sv
/*
  Constants for the windowed watchdog control block: register addresses,
  field positions, reset values and mode codes.
  Assumes an 8-bit register port addressed by the printed register addresses.
*/
package wwdc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // Register addresses
  localparam logic [11:0] OFS_CTRL_A   = 12'hecd;
  localparam logic [11:0] OFS_CTRL_B   = 12'hece;
  localparam logic [11:0] OFS_PSC_LOW  = 12'hecf;
  localparam logic [11:0] OFS_PSC_HIGH = 12'hed0;
  localparam logic [11:0] OFS_TMR_STAT = 12'hed1;

  // Field positions
  localparam int unsigned CA_EN_BIT  = 0;
  localparam int unsigned CA_PS_LSB  = 1;
  localparam int unsigned CA_PS_MSB  = 5;
  localparam int unsigned CB_WIN_LSB = 0;
  localparam int unsigned CB_WIN_MSB = 2;
  localparam int unsigned CB_CS_LSB  = 4;
  localparam int unsigned CB_CS_MSB  = 6;
  localparam int unsigned TS_PS_LSB  = 0;
  localparam int unsigned TS_PS_MSB  = 1;
  localparam int unsigned TS_ARM_BIT = 2;
  localparam int unsigned TS_TMR_LSB = 3;
  localparam int unsigned TS_TMR_MSB = 7;
  localparam int unsigned PSC_HI_LSB = 8;
  localparam int unsigned PSC_HI_MSB = 15;
  localparam int unsigned PSC_TOP_LSB = 16;
  localparam int unsigned PSC_TOP_MSB = 17;

  // Period select codes
  localparam logic [4:0] PS_UNLOCK  = 5'h1f;
  localparam logic [4:0] PS_DEFAULT = 5'h0b;
  localparam logic [4:0] PS_MAX     = 5'h12;
  localparam logic [4:0] PS_MIN     = 5'h00;

  // Clock select codes
  localparam logic [2:0] CS_UNLOCK  = 3'h7;
  localparam logic [2:0] CS_DEFAULT = 3'h0;
  localparam logic [2:0] CS_LFOSC   = 3'h0;
  localparam logic [2:0] CS_MFOSC   = 3'h1;

  // Window codes
  localparam logic [2:0] WIN_UNLOCK = 3'h7;
  localparam logic [2:0] WIN_OPEN   = 3'h7;

  // Enable modes
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [1:0] MODE_AWAKE  = 2'h2;
  localparam logic [1:0] MODE_SOFT   = 2'h1;
  localparam logic [1:0] MODE_OFF    = 2'h0;

  // Reset values; those of PS, CS and WIN are held until the configuration fields are loaded
  localparam logic       RST_SEN  = 1'b0;
  localparam logic [4:0] RST_PS   = 5'h0b;
  localparam logic [2:0] RST_CS   = 3'h0;
  localparam logic [2:0] RST_WIN  = 3'h7;
  localparam logic [7:0] RST_DATA = 8'h00;

endpackage

// >>> wwdc_top.sv
/*
  Windowed watchdog control: control registers, prescale counter, window
  timer, arming, clear handling, time-out and window violation events.
  Assumes a single-cycle register port from the CPU on core_clk, clear and
  sleep signals from core logic on the same clock, configuration fields that
  are stable from reset, and oscillator tick levels from other clock domains.
*/
// Our own choice: strobed register access.
`timescale 1ns/1ps

module wwdc_top
  import wwdc_pkg::*;
#(
  parameter int unsigned PSC_W = 18,
  parameter int unsigned TMR_W = 5
)
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output      logic [DATA_W-1:0] reg_rdata,
  input  wire logic [1:0]        config_enable_mode,
  input  wire logic [4:0]        config_period_field,
  input  wire logic [2:0]        config_clock_field,
  input  wire logic [2:0]        config_window_field,
  input  wire logic              low_freq_internal_osc,
  input  wire logic              medium_freq_internal_osc,
  input  wire logic              clear_instr,
  input  wire logic              sleep_mode,
  input  wire logic              sleep_exit_irq,
  input  wire logic              ost_running,
  output      logic              timeout_reset,
  output      logic              timeout_wake,
  output      logic              window_violation,
  output      logic              wdt_active,
  output      logic              window_open
);

  // Threshold step follows from 8 window codes over a 5-bit timer
  function automatic logic win_is_open(input logic [2:0] code,
                                       input logic [TMR_W-1:0] tmr);
    logic [TMR_W-1:0] thr;
    thr = TMR_W'({3'(WIN_OPEN - code), 2'b00});
    return tmr >= thr;
  endfunction

  function automatic logic [PSC_W-1:0] psc_mask(input logic [4:0] code);
    logic [4:0] eff;
    eff = (code > PS_MAX) ? PS_MIN : code;
    return ~({PSC_W{1'b1}} << eff);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // Oscillator tick synchronisers; only the second stage feeds logic
  logic [1:0] lf_sync_q;
  logic [1:0] mf_sync_q;
  logic       lf_prev_q;
  logic       mf_prev_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lf_sync_q <= 2'b00;
      mf_sync_q <= 2'b00;
      lf_prev_q <= 1'b0;
      mf_prev_q <= 1'b0;
    end
    else
    begin
      lf_sync_q <= {lf_sync_q[0], low_freq_internal_osc};
      mf_sync_q <= {mf_sync_q[0], medium_freq_internal_osc};
      lf_prev_q <= lf_sync_q[1];
      mf_prev_q <= mf_sync_q[1];
    end
  end

  logic lf_tick;
  logic mf_tick;
  assign lf_tick = lf_sync_q[1] && !lf_prev_q;
  assign mf_tick = mf_sync_q[1] && !mf_prev_q;

  // Control registers
  logic             load_pend_q;
  logic             load_pend_d;
  logic             sen_q;
  logic             sen_d;
  logic [4:0]       ps_q;
  logic [4:0]       ps_d;
  logic [2:0]       cs_q;
  logic [2:0]       cs_d;
  logic [2:0]       win_q;
  logic [2:0]       win_d;

  logic wr_a;
  logic wr_b;
  logic rd_a;
  assign wr_a = reg_wr && hit(reg_addr, OFS_CTRL_A);
  assign wr_b = reg_wr && hit(reg_addr, OFS_CTRL_B);
  assign rd_a = reg_rd && hit(reg_addr, OFS_CTRL_A);

  always_comb
  begin
    load_pend_d = 1'b0;
    sen_d       = sen_q;
    ps_d        = ps_q;
    cs_d        = cs_q;
    win_d       = win_q;
    if (load_pend_q)
    begin
      // Configuration is caught on the first edge after reset release
      ps_d  = (config_period_field == PS_UNLOCK) ? PS_DEFAULT
                                                 : config_period_field;
      cs_d  = (config_clock_field == CS_UNLOCK) ? CS_DEFAULT
                                                : config_clock_field;
      win_d = config_window_field;
    end
    else
    begin
      if (wr_a)
      begin
        sen_d = reg_wdata[CA_EN_BIT];
        if (config_period_field == PS_UNLOCK)
        begin
          ps_d = reg_wdata[CA_PS_MSB:CA_PS_LSB];
        end
      end
      if (wr_b)
      begin
        if (config_clock_field == CS_UNLOCK)
        begin
          cs_d = reg_wdata[CB_CS_MSB:CB_CS_LSB];
        end
        if (config_window_field == WIN_UNLOCK)
        begin
          win_d = reg_wdata[CB_WIN_MSB:CB_WIN_LSB];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_pend_q <= 1'b1;
      sen_q       <= RST_SEN;
      ps_q        <= RST_PS;
      cs_q        <= RST_CS;
      win_q       <= RST_WIN;
    end
    else
    begin
      load_pend_q <= load_pend_d;
      sen_q       <= sen_d;
      ps_q        <= ps_d;
      cs_q        <= cs_d;
      win_q       <= win_d;
    end
  end

  // Operating mode
  logic active;
  always_comb
  begin
    case (config_enable_mode)
      MODE_ALWAYS: active = 1'b1;
      MODE_AWAKE:  active = !sleep_mode;
      MODE_SOFT:   active = sen_q;
      MODE_OFF:    active = 1'b0;
      default:     active = 1'b0;
    endcase
  end

  // Reserved clock codes give no time base, so the count stalls
  logic tick;
  always_comb
  begin
    case (cs_q)
      CS_LFOSC: tick = lf_tick;
      CS_MFOSC: tick = mf_tick;
      default:  tick = 1'b0;
    endcase
  end

  // Counting, clearing, arming and events
  logic [PSC_W-1:0] psc_q;
  logic [PSC_W-1:0] psc_d;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] tmr_d;
  logic             armed_q;
  logic             armed_d;
  logic             sleep_q;
  logic             rst_ev_q;
  logic             rst_ev_d;
  logic             wake_ev_q;
  logic             wake_ev_d;
  logic             viol_q;
  logic             viol_d;

  logic windowed;
  logic is_open;
  logic clr_ok;
  logic viol;
  logic terminal;
  logic tmo;
  logic cnt_clr;

  assign windowed = (win_q != WIN_OPEN);
  assign is_open  = win_is_open(win_q, tmr_q);
  assign terminal = tick && ((psc_q & psc_mask(ps_q)) == psc_mask(ps_q));
  assign tmo      = active && terminal && (tmr_q == {TMR_W{1'b1}});
  // In windowed mode a closed window or a missing arm both count as violations
  assign clr_ok   = !windowed || (armed_q && is_open);
  assign viol     = active && clear_instr && !clr_ok;

  always_comb
  begin
    // Clears, time-out and violation all restart the period
    cnt_clr = !active || (clear_instr && clr_ok) || (sleep_mode && !sleep_q)
              || sleep_exit_irq || ost_running || wr_a || wr_b || viol || tmo;
    psc_d = psc_q;
    tmr_d = tmr_q;
    if (cnt_clr)
    begin
      psc_d = '0;
      tmr_d = '0;
    end
    else if (terminal)
    begin
      psc_d = '0;
      tmr_d = tmr_q + 1'b1;
    end
    else if (tick)
    begin
      psc_d = psc_q + 1'b1;
    end
    armed_d = armed_q;
    if (cnt_clr)
    begin
      armed_d = 1'b0;
    end
    else if (rd_a)
    begin
      armed_d = 1'b1;
    end
    rst_ev_d  = (tmo && !sleep_mode) || viol;
    wake_ev_d = tmo && sleep_mode;
    viol_d    = viol;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      psc_q     <= '0;
      tmr_q     <= '0;
      armed_q   <= 1'b0;
      sleep_q   <= 1'b0;
      rst_ev_q  <= 1'b0;
      wake_ev_q <= 1'b0;
      viol_q    <= 1'b0;
    end
    else
    begin
      psc_q     <= psc_d;
      tmr_q     <= tmr_d;
      armed_q   <= armed_d;
      sleep_q   <= sleep_mode;
      rst_ev_q  <= rst_ev_d;
      wake_ev_q <= wake_ev_d;
      viol_q    <= viol_d;
    end
  end

  assign timeout_reset    = rst_ev_q;
  assign timeout_wake     = wake_ev_q;
  assign window_violation = viol_q;
  assign wdt_active       = active;
  assign window_open      = is_open;

  // Register read port, data one cycle after the strobe
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  always_comb
  begin
    rdata_d = RST_DATA;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL_A:
        begin
          rdata_d[CA_EN_BIT]           = sen_q;
          rdata_d[CA_PS_MSB:CA_PS_LSB] = ps_q;
        end
        OFS_CTRL_B:
        begin
          rdata_d[CB_CS_MSB:CB_CS_LSB]   = cs_q;
          rdata_d[CB_WIN_MSB:CB_WIN_LSB] = win_q;
        end
        // Writes to the three status addresses have no decode at all
        OFS_PSC_LOW:  rdata_d = psc_q[DATA_W-1:0];
        OFS_PSC_HIGH: rdata_d = psc_q[PSC_HI_MSB:PSC_HI_LSB];
        OFS_TMR_STAT:
        begin
          rdata_d[TS_TMR_MSB:TS_TMR_LSB] = tmr_q;
          rdata_d[TS_ARM_BIT]            = armed_q;
          rdata_d[TS_PS_MSB:TS_PS_LSB]   = psc_q[PSC_TOP_MSB:PSC_TOP_LSB];
        end
        default: rdata_d = RST_DATA;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= RST_DATA;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// >>> wwdc_properties.sv
/*
  Port-level assertions for the windowed watchdog control block.
  Bound to wwdc_top from the bench; sees its ports only.
*/
`timescale 1ns/1ps
module wwdc_properties
  import wwdc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [1:0]  config_enable_mode,
  input wire logic        clear_instr,
  input wire logic        sleep_mode,
  input wire logic        timeout_reset,
  input wire logic        timeout_wake,
  input wire logic        window_violation,
  input wire logic        wdt_active,
  input wire logic        window_open
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  ctrl_a_pad_a: assert property (reg_rd && reg_addr == OFS_CTRL_A |=> reg_rdata[7:6] == 2'h0)
    else $error("unused control A bits not zero");
  ctrl_b_pad_a: assert property (reg_rd && reg_addr == OFS_CTRL_B |=> !reg_rdata[7] && !reg_rdata[3])
    else $error("unused control B bits not zero");
  viol_reset_a: assert property (window_violation |-> timeout_reset)
    else $error("violation without reset pulse");
  viol_cause_a: assert property (window_violation |-> $past(clear_instr) && $past(wdt_active))
    else $error("violation without a clear");
  viol_clears_a: assert property (window_violation |-> !window_open)
    else $error("count not cleared on violation");
  pulse_short_a: assert property (timeout_reset |=> !timeout_reset)
    else $error("reset pulse longer than one cycle");
  wake_sleep_a: assert property (timeout_wake |-> $past(sleep_mode) && !timeout_reset)
    else $error("wake pulse while awake");
  mode_on_a: assert property (config_enable_mode == MODE_ALWAYS |-> wdt_active)
    else $error("always-on mode inactive");
  mode_off_a: assert property (config_enable_mode == MODE_OFF |-> !wdt_active)
    else $error("off mode active");
  idle_clear_a: assert property (clear_instr && !wdt_active |=> !window_violation)
    else $error("clear acted while inactive");
endmodule

// >>> tb.sv
/*
  Self-checking bench for wwdc_top: register access, locks, window,
  arming, time-out and wake. Oscillators are driven as slow levels.
*/
`timescale 1ns/1ps
module tb
  import wwdc_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [1:0]  config_enable_mode = 2'h0;
  logic [4:0]  config_period_field = 5'h00;
  logic [2:0]  config_clock_field = 3'h0;
  logic [2:0]  config_window_field = 3'h0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, clear_instr = 1'b0, sleep_mode = 1'b0;
  logic        low_freq_internal_osc = 1'b0, medium_freq_internal_osc = 1'b0;
  logic        sleep_exit_irq = 1'b0, ost_running = 1'b0, hit_r, hit_w;
  logic        timeout_reset, timeout_wake, window_violation, wdt_active, window_open;
  int          num_errors = 0, n_tests = 0, cycles = 0, k;

  wwdc_top u_wwdc_top (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .config_enable_mode, .config_period_field, .config_clock_field,
    .config_window_field, .low_freq_internal_osc, .medium_freq_internal_osc,
    .clear_instr, .sleep_mode, .sleep_exit_irq, .ost_running, .timeout_reset,
    .timeout_wake, .window_violation, .wdt_active, .window_open);

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  // Longest run is about 16k cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic checkb(input logic got, input logic exp);
    check({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic do_reset(input logic [1:0] m, input logic [4:0] p, input logic [2:0] c,
                          input logic [2:0] w);
    @(posedge core_clk);
    rst_n <= 1'b0;
    config_enable_mode <= m;
    config_period_field <= p;
    config_clock_field <= c;
    config_window_field <= w;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic clr(input logic exp);
    @(posedge core_clk);
    clear_instr <= 1'b1;
    @(posedge core_clk);
    clear_instr <= 1'b0;
    #1 checkb(window_violation, exp);
    checkb(timeout_reset, exp);
  endtask

  // Stops early once a time-out pulse is seen; k holds ticks sent
  task automatic tick(input logic med, input int n);
    hit_r = 1'b0;
    hit_w = 1'b0;
    for (k = 0; k < n && !(hit_r || hit_w); k++)
      for (int c = 0; c < 8; c++)
      begin
        @(posedge core_clk);
        low_freq_internal_osc <= !med && c < 4;
        medium_freq_internal_osc <= med && c < 4;
        #1;
        hit_r |= timeout_reset === 1'b1;
        hit_w |= timeout_wake === 1'b1;
      end
  endtask

  task automatic tmo(input logic [4:0] code, input logic med, input int exp);
    wr(OFS_CTRL_A, {2'b00, code, 1'b1});
    tick(med, exp + 4);
    check(16'(k), 16'(exp));
    checkb(hit_w, sleep_mode);
    checkb(hit_r, !sleep_mode);
  endtask

  initial
  begin
    do_reset(MODE_SOFT, 5'h1f, 3'h7, 3'h7);
    rd(OFS_CTRL_A, 8'h16);
    rd(OFS_CTRL_B, 8'h07);
    checkb(wdt_active, 1'b0);
    for (logic [11:0] a = OFS_PSC_LOW; a <= OFS_TMR_STAT; a++)
    begin
      wr(a, 8'hff);
      rd(a, 8'h00);
    end
    rd(12'h000, 8'h00);
    wr(OFS_CTRL_A, 8'hff);
    rd(OFS_CTRL_A, 8'h3f);
    checkb(wdt_active, 1'b1);
    wr(OFS_CTRL_B, 8'hff);
    rd(OFS_CTRL_B, 8'h77);
    wr(OFS_CTRL_A, 8'h01);
    for (int c = 0; c < 7; c++)
    begin
      wr(OFS_CTRL_B, 8'(c));
      tick(1'b0, 27 - 4 * c);
      checkb(window_open, 1'b0);
      tick(1'b0, 1);
      checkb(window_open, 1'b1);
    end
    clr(1'b1);
    tick(1'b0, 4);
    rd(OFS_CTRL_A, 8'h01);
    rd(OFS_TMR_STAT, 8'h24);
    clr(1'b0);
    rd(OFS_TMR_STAT, 8'h00);
    tick(1'b0, 2);
    rd(OFS_TMR_STAT, 8'h10);
    @(posedge core_clk);
    ost_running <= 1'b1;
    @(posedge core_clk);
    ost_running <= 1'b0;
    rd(OFS_TMR_STAT, 8'h00);
    tick(1'b0, 1);
    rd(OFS_TMR_STAT, 8'h08);
    @(posedge core_clk);
    sleep_exit_irq <= 1'b1;
    @(posedge core_clk);
    sleep_exit_irq <= 1'b0;
    rd(OFS_TMR_STAT, 8'h00);
    tick(1'b0, 2);
    rd(OFS_CTRL_A, 8'h01);
    clr(1'b1);
    wr(OFS_CTRL_A, 8'h13);
    tick(1'b0, 300);
    rd(OFS_PSC_LOW, 8'h2c);
    rd(OFS_PSC_HIGH, 8'h01);
    wr(OFS_CTRL_B, 8'h07);
    rd(OFS_PSC_LOW, 8'h00);
    tmo(5'h00, 1'b0, 32);
    tmo(5'h01, 1'b0, 64);
    tmo(5'h05, 1'b0, 1024);
    tmo(5'h13, 1'b0, 32);
    tmo(5'h1f, 1'b0, 32);
    @(posedge core_clk) sleep_mode <= 1'b1;
    tmo(5'h00, 1'b0, 32);
    @(posedge core_clk) sleep_mode <= 1'b0;
    wr(OFS_CTRL_B, 8'h17);
    tmo(5'h00, 1'b1, 32);
    wr(OFS_CTRL_A, 8'h00);
    #1 checkb(wdt_active, 1'b0);
    do_reset(MODE_ALWAYS, 5'h03, 3'h1, 3'h2);
    rd(OFS_CTRL_A, 8'h06);
    rd(OFS_CTRL_B, 8'h12);
    wr(OFS_CTRL_A, 8'h3e);
    wr(OFS_CTRL_B, 8'h65);
    rd(OFS_CTRL_A, 8'h06);
    rd(OFS_CTRL_B, 8'h12);
    checkb(wdt_active, 1'b1);
    wr(OFS_CTRL_B, 8'h00);
    clr(1'b1);
    tmo(5'h03, 1'b1, 256);
    @(posedge core_clk) sleep_mode <= 1'b1;
    do_reset(MODE_AWAKE, 5'h00, 3'h7, 3'h7);
    checkb(wdt_active, 1'b0);
    sleep_mode <= 1'b0;
    #1 checkb(wdt_active, 1'b1);
    do_reset(MODE_OFF, 5'h00, 3'h7, 3'h2);
    checkb(wdt_active, 1'b0);
    clr(1'b0);
    finish_test();
  end
endmodule

bind wwdc_top wwdc_properties u_wwdc_properties (.core_clk, .rst_n, .reg_addr, .reg_rd,
  .reg_rdata, .config_enable_mode, .clear_instr, .sleep_mode, .timeout_reset,
  .timeout_wake, .window_violation, .wdt_active, .window_open);
